// ==== rpc_pkg.sv ====
/*
  constants for the reset, supply and clock supervisor: register map,
  field positions, reset-cause bits, mode and source codes and timing counts.
  assumes a single 20 MHz system clock.
*/
`default_nettype none
package rpc_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] A_PWR_CTRL = 8'h00;
  localparam logic [7:0] A_PWR_STAT = 8'h04;
  localparam logic [7:0] A_LINE16 = 8'h08;
  localparam logic [7:0] A_RCSR = 8'h0c;
  localparam logic [7:0] A_SWRST = 8'h10;
  localparam logic [7:0] A_CLK = 8'h14;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PC_THR = 0;
  localparam int PC_DEN = 4;
  localparam int PC_MODE = 5;
  localparam int PC_LPRST = 8;
  localparam int PS_FLAG = 0;
  localparam int PS_MODE = 1;
  localparam int L_EN = 0;
  localparam int L_RISE = 1;
  localparam int L_FALL = 2;
  localparam int L_PEND = 3;
  localparam int RC_CLR = 24;
  localparam int SR_REQ = 0;
  localparam int CK_IFO = 0;
  localparam int CK_EFO = 1;
  localparam int CK_PLL = 2;
  localparam int CK_ISO = 3;
  localparam int CK_ESO = 4;
  localparam int CK_EBYP = 5;
  localparam int CK_SBYP = 6;
  localparam int CK_SW = 8;
  localparam int CK_MCO = 10;
  localparam int CK_MALT = 12;
  localparam int CK_RTC = 13;
  localparam int CK_MUL = 16;
  localparam int CK_PSRC = 20;
  localparam int CK_SWS = 24;
  localparam int CK_ERDY = 28;
  localparam int CK_SRDY = 29;
  localparam int CK_PRDY = 30;
  // reset-cause flag bits
  localparam int C_PIN = 0;
  localparam int C_POR = 1;
  localparam int C_SW = 2;
  localparam int C_INDEPENDENT_WATCHDOG = 3;
  localparam int C_WINDOW_WATCHDOG = 4;
  localparam int C_LP = 5;
  // ----------------------------------------
  // codes and modes
  // ----------------------------------------
  typedef enum logic [1:0] {RPC_RUN, RPC_STOP, RPC_STANDBY} rpc_mode_t;
  localparam logic [1:0] MODE_STOP = 2'h1;
  localparam logic [1:0] MODE_STANDBY = 2'h2;
  localparam logic [1:0] SRC_IFO = 2'h0;
  localparam logic [1:0] SRC_EFO = 2'h1;
  localparam logic [1:0] SRC_PLL = 2'h2;
  localparam logic [1:0] MCO_SYS = 2'h0;
  localparam logic [1:0] MCO_IFO = 2'h1;
  localparam logic [1:0] MCO_EFO = 2'h2;
  localparam logic [1:0] MCO_PLL2 = 2'h3;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_MHZ = 20;
  localparam int ISO_HZ = 40_000;
  localparam logic [8:0] ISO_DIV = 9'(CLK_HZ / ISO_HZ);
  localparam int RST_HOLD_NS = 200;
  localparam logic [3:0] RST_HOLD = 4'((RST_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam int PLL_LIMIT_KHZ = 64_000;
  localparam int PLL_MUL_BASE = 2;
endpackage : rpc_pkg
`default_nettype wire

// ==== rpc_supervisor.sv ====
/*
  reset, supply supervision and clock-source control, one clock domain.
  assumes: comparator and pin inputs are asynchronous, watchdog end-of-count
  pulses come from logic on clk, software uses the plain register port.
*/
// The strobed register port and the placing of the registers were chosen for this implementation.
// What this block does
// (RQ1) regulator on and in run after reset
// (RQ2) run mode: regulator at full power
// (RQ3) stop mode: low power, state kept
// (RQ4) standby: regulator off, state lost
// (RQ5) hold reset while supply below threshold
// (RQ6) 3-bit field selects detector threshold
// (RQ7) detector works only when enabled
// (RQ8) status flag shows supply versus threshold
// (RQ9) detector drives line 16 when enabled
// (RQ10) line 16 fires on chosen edges
// (RQ11) system reset clears all but cause flags
// (RQ12) five events raise a system reset
// (RQ13) distinct readable reset-cause flags
// (RQ14) cause flags stay until software clears
// (RQ15) system clock from three sources
// (RQ16) internal slow clock feeds watchdog, calendar
// (RQ17) external slow clock may feed calendar
// (RQ18) each source switched on/off alone
// (RQ19) internal-fed pll above 64 MHz never used as system clock
// (RQ20) bypass fast clock driven by other party
// (RQ21) bypass slow clock driven by other party
// (RQ22) output mux picks one of four
// (RQ23) output clock only in alternate mode
`timescale 1ns/1ps
`default_nettype none
module rpc_supervisor #(
  parameter int IFO_KHZ = 8000
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // pins and analog monitors
  input wire logic external_reset_pin_n,
  input wire logic por_below,
  input wire logic [7:0] detector_below,
  input wire logic fast_osc_input,
  input wire logic slow_osc_input,
  input wire logic wakeup,
  // watchdog end-of-count pulses
  input wire logic window_watchdog_end,
  input wire logic independent_watchdog_end,
  // reset and regulator
  output logic sys_reset_n,
  output logic regulator_on,
  output logic regulator_low_power,
  output logic line16_irq,
  // clocks
  output logic fast_osc_amp_en,
  output logic slow_osc_amp_en,
  output logic system_tick,
  output logic calendar_tick,
  output logic watchdog_tick,
  output logic clock_output,
  output logic clock_output_oe_n
);
  if (IFO_KHZ < 1 || IFO_KHZ > 1_000_000) begin : g_chk
    $error("IFO_KHZ out of range");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic r1, r2, p1, p2, e1, e2, eprev, s1, s2, sprev, w1, w2;
    logic [7:0] c1, c2;
    logic [2:0] thr;
    logic den;
    rpc_pkg::rpc_mode_t mode;
    logic lprst, len, lrise, lfall, pend, dflag, dprev;
    logic [5:0] flags;
    logic [3:0] rcnt;
    logic srst_n, reg_on, reg_lp;
    logic ifo_on, efo_on, pll_on, iso_on, eso_on, ebyp, sbyp;
    logic [1:0] sw, sws, clock_output_mux;
    logic malt, rtc;
    logic [3:0] mul;
    logic psrc, erdy, srdy, phalf;
    logic [8:0] icnt;
    logic mco_out, mco_oe_n, e_amp, s_amp, irq, sys_t, rtc_t, wdg_t;
    logic [31:0] rdata;
  } rpc_state_t;

  rpc_state_t st;
  rpc_state_t nx;
  logic req;

  function automatic logic too_fast(input logic [3:0] mul);
    int f;
    f = (IFO_KHZ / 2) * (int'(mul) + rpc_pkg::PLL_MUL_BASE);
    return f > rpc_pkg::PLL_LIMIT_KHZ;
  endfunction : too_fast

  // register defaults; cause flags and synchronisers are kept
  function automatic rpc_state_t defaults(input rpc_state_t s);
    rpc_state_t d;
    d = '0;
    d.r1 = s.r1; d.r2 = s.r2; d.p1 = s.p1; d.p2 = s.p2;
    d.e1 = s.e1; d.e2 = s.e2; d.eprev = s.eprev;
    d.s1 = s.s1; d.s2 = s.s2; d.sprev = s.sprev;
    d.w1 = s.w1; d.w2 = s.w2; d.c1 = s.c1; d.c2 = s.c2;
    d.flags = s.flags; // RQ11 RQ14
    d.rcnt = s.rcnt;
    d.mode = rpc_pkg::RPC_RUN; // RQ1
    d.reg_on = 1'b1; // RQ1
    d.ifo_on = 1'b1;
    d.sw = rpc_pkg::SRC_IFO;
    d.sws = rpc_pkg::SRC_IFO;
    d.mco_oe_n = 1'b1;
    d.e_amp = 1'b0;
    return d;
  endfunction : defaults

  function automatic rpc_state_t power_on();
    rpc_state_t d;
    d = defaults('0);
    d.r1 = 1'b1;
    d.r2 = 1'b1;
    d.flags[rpc_pkg::C_POR] = 1'b1;
    d.rcnt = rpc_pkg::RST_HOLD;
    return d;
  endfunction : power_on

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic ifo_t, iso_t, efo_t, eso_t, pll_t, sys_t, mco_t, src_rdy;
    logic rose, fell, wake_rst, lp_rst, sw_rst, wr_ok;
    logic [5:0] ev;
    logic [1:0] tgt;
    ifo_t = 1'b0; iso_t = 1'b0; efo_t = 1'b0; eso_t = 1'b0;
    pll_t = 1'b0; sys_t = 1'b0; mco_t = 1'b0; src_rdy = 1'b0;
    rose = 1'b0; fell = 1'b0; wake_rst = 1'b0; lp_rst = 1'b0;
    sw_rst = 1'b0; ev = '0; tgt = '0;
    wr_ok = wr & st.srst_n;
    nx = st;
    // synchronisers: first stage only feeds the second
    nx.r1 = external_reset_pin_n; nx.r2 = st.r1;
    nx.p1 = por_below; nx.p2 = st.p1;
    nx.c1 = detector_below; nx.c2 = st.c1;
    nx.e1 = fast_osc_input; nx.e2 = st.e1; nx.eprev = st.e2;
    nx.s1 = slow_osc_input; nx.s2 = st.s1; nx.sprev = st.s2;
    nx.w1 = wakeup; nx.w2 = st.w1;

    // clock sources, each with its own enable
    ifo_t = st.ifo_on; // RQ18
    efo_t = st.efo_on & st.e2 & ~st.eprev; // RQ18
    eso_t = st.eso_on & st.s2 & ~st.sprev; // RQ18
    iso_t = st.iso_on && st.icnt == rpc_pkg::ISO_DIV - 9'h1;
    nx.icnt = (!st.iso_on || iso_t) ? 9'h0 : st.icnt + 9'h1;
    nx.erdy = st.efo_on & (st.erdy | efo_t);
    nx.srdy = st.eso_on & (st.srdy | eso_t);
    pll_t = st.pll_on & (st.psrc ? efo_t : ifo_t);
    if (pll_t) begin
      nx.phalf = ~st.phalf;
    end
    unique case (st.sws) // RQ15
      rpc_pkg::SRC_EFO: sys_t = efo_t;
      rpc_pkg::SRC_PLL: sys_t = pll_t;
      default: sys_t = ifo_t;
    endcase
    nx.sys_t = sys_t & (st.mode == rpc_pkg::RPC_RUN);
    nx.wdg_t = iso_t; // RQ16
    nx.rtc_t = st.rtc ? eso_t : iso_t; // RQ16 RQ17
    nx.e_amp = st.efo_on & ~st.ebyp;
    nx.s_amp = st.eso_on & ~st.sbyp;

    // switch only to a ready source; pll off internal source capped
    tgt = st.sw;
    unique case (tgt)
      rpc_pkg::SRC_EFO: src_rdy = st.erdy;
      rpc_pkg::SRC_PLL: src_rdy = st.pll_on && (st.psrc ? st.erdy : st.ifo_on)
                                  && (st.psrc || !too_fast(st.mul)); // RQ19
      default: src_rdy = st.ifo_on;
    endcase
    if (src_rdy && tgt != 2'h3) begin
      nx.sws = tgt;
    end

    // clock output mux
    unique case (st.clock_output_mux) // RQ22
      rpc_pkg::MCO_SYS: mco_t = sys_t;
      rpc_pkg::MCO_IFO: mco_t = ifo_t;
      rpc_pkg::MCO_EFO: mco_t = efo_t;
      default: mco_t = pll_t & st.phalf;
    endcase
    nx.mco_oe_n = ~st.malt; // RQ23
    nx.mco_out = st.malt & (mco_t ? ~st.mco_out : st.mco_out); // RQ23

    // supply voltage detector and line 16
    nx.dflag = st.den & st.c2[st.thr]; // RQ6 RQ7 RQ8
    nx.dprev = st.dflag;
    rose = st.dflag & ~st.dprev;
    fell = ~st.dflag & st.dprev;

    // register writes
    if (wr_ok) begin
      unique case (addr)
        rpc_pkg::A_PWR_CTRL: begin
          nx.thr = wdata[rpc_pkg::PC_THR +: 3]; // RQ6
          nx.den = wdata[rpc_pkg::PC_DEN]; // RQ7
          nx.lprst = wdata[rpc_pkg::PC_LPRST];
          if (st.mode == rpc_pkg::RPC_RUN) begin
            if (wdata[rpc_pkg::PC_MODE +: 2] == rpc_pkg::MODE_STOP) begin
              lp_rst = wdata[rpc_pkg::PC_LPRST];
              nx.mode = rpc_pkg::RPC_STOP;
              nx.reg_lp = 1'b1; // RQ3
            end else if (wdata[rpc_pkg::PC_MODE +: 2] == rpc_pkg::MODE_STANDBY) begin
              lp_rst = wdata[rpc_pkg::PC_LPRST];
              nx.mode = rpc_pkg::RPC_STANDBY;
              nx.reg_on = 1'b0; // RQ4
            end
          end
        end
        rpc_pkg::A_LINE16: begin
          nx.len = wdata[rpc_pkg::L_EN];
          nx.lrise = wdata[rpc_pkg::L_RISE];
          nx.lfall = wdata[rpc_pkg::L_FALL];
          if (wdata[rpc_pkg::L_PEND]) begin
            nx.pend = 1'b0;
          end
        end
        rpc_pkg::A_RCSR: begin
          if (wdata[rpc_pkg::RC_CLR]) begin
            nx.flags = '0;
          end
        end
        rpc_pkg::A_SWRST: sw_rst = wdata[rpc_pkg::SR_REQ];
        rpc_pkg::A_CLK: begin
          // the source in use cannot be stopped
          nx.ifo_on = wdata[rpc_pkg::CK_IFO] | (nx.sws == rpc_pkg::SRC_IFO)
                      | (nx.sws == rpc_pkg::SRC_PLL && !st.psrc); // RQ18
          nx.efo_on = wdata[rpc_pkg::CK_EFO] | (nx.sws == rpc_pkg::SRC_EFO)
                      | (nx.sws == rpc_pkg::SRC_PLL && st.psrc);
          nx.pll_on = wdata[rpc_pkg::CK_PLL] | (nx.sws == rpc_pkg::SRC_PLL);
          nx.iso_on = wdata[rpc_pkg::CK_ISO];
          nx.eso_on = wdata[rpc_pkg::CK_ESO];
          nx.ebyp = wdata[rpc_pkg::CK_EBYP];
          nx.sbyp = wdata[rpc_pkg::CK_SBYP];
          nx.sw = wdata[rpc_pkg::CK_SW +: 2];
          nx.clock_output_mux = wdata[rpc_pkg::CK_MCO +: 2];
          nx.malt = wdata[rpc_pkg::CK_MALT];
          nx.rtc = wdata[rpc_pkg::CK_RTC];
          if (nx.sws != rpc_pkg::SRC_PLL) begin // RQ19
            nx.mul = wdata[rpc_pkg::CK_MUL +: 4];
            nx.psrc = wdata[rpc_pkg::CK_PSRC];
          end
        end
        default: ;
      endcase
    end
    // a detector edge in the clearing cycle wins
    if (st.len && ((st.lrise && rose) || (st.lfall && fell))) begin // RQ10
      nx.pend = 1'b1;
    end
    if (!nx.len) begin
      nx.pend = 1'b0; // RQ9
    end
    nx.irq = nx.pend; // RQ9

    // low-power wakeup
    if (st.mode == rpc_pkg::RPC_STOP && st.w2) begin
      nx.mode = rpc_pkg::RPC_RUN; // RQ2
      nx.reg_lp = 1'b0;
    end
    wake_rst = st.mode == rpc_pkg::RPC_STANDBY && st.w2; // RQ4

    // reset sources and cause flags, set wins over clear
    ev[rpc_pkg::C_PIN] = ~st.r2; // RQ12
    ev[rpc_pkg::C_POR] = st.p2; // RQ5
    ev[rpc_pkg::C_SW] = sw_rst; // RQ12
    ev[rpc_pkg::C_INDEPENDENT_WATCHDOG] = independent_watchdog_end; // RQ12
    ev[rpc_pkg::C_WINDOW_WATCHDOG] = window_watchdog_end; // RQ12
    ev[rpc_pkg::C_LP] = lp_rst; // RQ12
    nx.flags = nx.flags | ev; // RQ13 RQ14
    req = (|ev) | wake_rst;

    // read data, valid the cycle after the strobe only
    nx.rdata = '0;
    if (rd) begin
      unique case (addr)
        rpc_pkg::A_PWR_CTRL: nx.rdata = {23'h0, st.lprst, 3'h0, st.den, 1'b0, st.thr};
        rpc_pkg::A_PWR_STAT: nx.rdata = {29'h0, st.mode, st.dflag}; // RQ8
        rpc_pkg::A_LINE16: nx.rdata = {28'h0, st.pend, st.lfall, st.lrise, st.len};
        rpc_pkg::A_RCSR: nx.rdata = {26'h0, st.flags}; // RQ13
        rpc_pkg::A_CLK: nx.rdata = {1'b0, st.pll_on && (st.psrc ? st.erdy : st.ifo_on),
                                    st.srdy, st.erdy, 2'h0, st.sws, 3'h0, st.psrc,
                                    st.mul, 2'h0, st.rtc, st.malt, st.clock_output_mux, st.sw,
                                    1'b0, st.sbyp, st.ebyp, st.eso_on, st.iso_on,
                                    st.pll_on, st.efo_on, st.ifo_on};
        default: nx.rdata = '0;
      endcase
    end

    // system reset: registers back to defaults, flags kept
    if (req) begin
      nx = defaults(nx); // RQ11
      nx.rcnt = rpc_pkg::RST_HOLD; // RQ5
    end else if (st.rcnt != 4'h0) begin
      nx.rcnt = st.rcnt - 4'h1;
    end
    nx.srst_n = ~req && nx.rcnt == 4'h0; // RQ5 RQ12
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= power_on();
    end else begin
      st <= nx;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata = st.rdata;
  assign sys_reset_n = st.srst_n;
  assign regulator_on = st.reg_on;
  assign regulator_low_power = st.reg_lp;
  assign line16_irq = st.irq;
  assign fast_osc_amp_en = st.e_amp;
  assign slow_osc_amp_en = st.s_amp;
  assign system_tick = st.sys_t;
  assign calendar_tick = st.rtc_t;
  assign watchdog_tick = st.wdg_t;
  assign clock_output = st.mco_out;
  assign clock_output_oe_n = st.mco_oe_n;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_rise_seen;
    st.len && st.lrise && st.dflag && !st.dprev && !req
      && !(wr && addr == rpc_pkg::A_LINE16);
  endsequence
  sequence s_sw_request;
    wr && addr == rpc_pkg::A_SWRST && wdata[rpc_pkg::SR_REQ] && st.srst_n;
  endsequence

  a_reg_after_reset: assert property ($rose(st.srst_n) |-> regulator_on && // RQ1
    !regulator_low_power && st.mode == rpc_pkg::RPC_RUN) else $error("regulator not in run");
  a_run_full_power: assert property (st.mode == rpc_pkg::RPC_RUN |-> // RQ2
    st.reg_on && !st.reg_lp) else $error("run mode not at full power");
  a_stop_low_power: assert property (st.mode == rpc_pkg::RPC_STOP |-> // RQ3
    st.reg_on && st.reg_lp) else $error("stop mode power wrong");
  a_standby_off: assert property (st.mode == rpc_pkg::RPC_STANDBY |-> // RQ4
    !st.reg_on) else $error("standby regulator on");
  a_por_holds_reset: assert property (st.p2 |=> !sys_reset_n [*4]) // RQ5
    else $error("reset released under low supply");
  a_det_disabled: assert property (!st.den |=> !st.dflag) // RQ7
    else $error("detector flag while disabled");
  a_det_select: assert property (st.den && !req |=> // RQ6
    st.dflag == $past(st.c2[st.thr])) else $error("detector flag mismatch");
  a_line_gate: assert property (!st.len |=> !line16_irq) // RQ9
    else $error("line 16 raised while disabled");
  a_rise_irq: assert property (s_rise_seen |=> st.pend && line16_irq) // RQ10
    else $error("rising edge lost");
  a_sw_cause: assert property (s_sw_request |=> st.flags[rpc_pkg::C_SW] && // RQ13
    !sys_reset_n) else $error("software reset not recorded");
  a_flag_sticky: assert property (st.flags[rpc_pkg::C_SW] && !(wr && // RQ14
    addr == rpc_pkg::A_RCSR && wdata[rpc_pkg::RC_CLR]) |=> st.flags[rpc_pkg::C_SW])
    else $error("cause flag lost");
  a_pll_limit: assert property (st.sws == rpc_pkg::SRC_PLL && !st.psrc |-> // RQ19
    !too_fast(st.mul)) else $error("pll above limit");
  a_mco_alt: assert property (!st.malt |=> clock_output_oe_n && !clock_output) // RQ23
    else $error("clock output outside alternate mode");
endmodule : rpc_supervisor
`default_nettype wire

// ==== rpc_far_side.sv ====
/*
  far-side model of the supervisor: reset pin and the two bypass clock sources.
  assumes the bench asks for a reset-pin pulse with a one-cycle request on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rpc_far_side (
  // clock
  input wire logic clk,
  // bench command
  input wire logic pin_req,
  // pins toward the block
  output logic external_reset_pin_n,
  output logic fast_osc_input,
  output logic slow_osc_input
);
  int hold = 0;
  // ----------------------------------------
  // bypass sources run free, both started low
  // ----------------------------------------
  initial begin
    fast_osc_input = 1'b0;
    slow_osc_input = 1'b0;
    fork
      forever #100 fast_osc_input = ~fast_osc_input;
      forever #15259 slow_osc_input = ~slow_osc_input;
    join_none
  end
  // ----------------------------------------
  // reset pin: six cycles low, longer than the two-stage sync needs
  // ----------------------------------------
  always @(posedge clk) begin
    if (pin_req) hold <= 6;
    else if (hold > 0) hold <= hold - 1;
    external_reset_pin_n <= !(pin_req || hold > 1);
  end
endmodule : rpc_far_side
`default_nettype wire

// ==== reset_power_clock_supervisor_tb_top.sv ====
/*
  self-checking bench for rpc_supervisor: reset sources, detector, modes, clocks.
  assumes the register port answers reads in the next cycle and never stalls.
*/
`timescale 1ns/1ps
`default_nettype none
module reset_power_clock_supervisor_tb_top;
  typedef struct packed {logic [31:0] e; logic [31:0] m;} rpc_note_t;
  logic clk, resetn, wr, rd, rd_d, pin_req, por_below, wakeup, ww_end, iw_end;
  logic [7:0] addr, detector_below;
  logic [31:0] wdata, rdata, acc;
  logic pin_n, fin, sin, srn, reg_on, reg_lp, irq, famp, samp, stick, ctick, wtick, cko, cko_oe_n;
  rpc_note_t notes[$];
  rpc_note_t n;
  int fail_count, checked, t, k, cnt, ccnt, scnt;
  rpc_supervisor DUT (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .external_reset_pin_n(pin_n), .por_below(por_below),
    .detector_below(detector_below), .fast_osc_input(fin), .slow_osc_input(sin),
    .wakeup(wakeup), .window_watchdog_end(ww_end), .independent_watchdog_end(iw_end),
    .sys_reset_n(srn), .regulator_on(reg_on), .regulator_low_power(reg_lp),
    .line16_irq(irq), .fast_osc_amp_en(famp), .slow_osc_amp_en(samp), .system_tick(stick),
    .calendar_tick(ctick), .watchdog_tick(wtick), .clock_output(cko),
    .clock_output_oe_n(cko_oe_n));
  rpc_far_side far (.clk(clk), .pin_req(pin_req), .external_reset_pin_n(pin_n),
    .fast_osc_input(fin), .slow_osc_input(sin));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("fail_count=%0d checked=%0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    notes.push_back('{e: e, m: m});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask : idle
  // bounded wait on the system reset output; a miss ends the run
  task automatic wait_sr(input logic v);
    int i;
    for (i = 0; i < 300 && srn !== v; i++) idle(1);
    if (srn !== v) begin
      fail_count++;
      close_out();
    end
  endtask : wait_sr
  // ----------------------------------------
  // read-data monitor: oldest note against rdata in the cycle after rd
  // ----------------------------------------
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d === 1'b1) begin
      n = notes.pop_front();
      chk(rdata & n.m, n.e & n.m);
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    close_out();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
    pin_req = 1'b0; por_below = 1'b0; wakeup = 1'b0; ww_end = 1'b0; iw_end = 1'b0;
    detector_below = 8'h00; fail_count = 0; checked = 0;
    void'($urandom(32'h12de837e));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    wait_sr(1'b1);
    chk(32'(reg_on), 32'h1);
    chk(32'(reg_lp), 32'h0);
    rd_reg(rpc_pkg::A_RCSR, 32'h2, 32'h3f);
    wr_reg(rpc_pkg::A_RCSR, 32'h1 << rpc_pkg::RC_CLR);
    acc = 32'h0;
    rd_reg(rpc_pkg::A_RCSR, acc, 32'h3f);
    // five sources in turn, all but power-on; flags pile up because only software clears them
    for (k = 0; k < 5; k++) begin
      wr_reg(rpc_pkg::A_PWR_CTRL, 32'h15);
      @(posedge clk);
      case (k)
        0: begin pin_req <= 1'b1; acc[rpc_pkg::C_PIN] = 1'b1; end
        1: begin addr <= rpc_pkg::A_SWRST; wdata <= 32'h1; wr <= 1'b1; acc[rpc_pkg::C_SW] = 1'b1; end
        2: begin iw_end <= 1'b1; acc[rpc_pkg::C_INDEPENDENT_WATCHDOG] = 1'b1; end
        3: begin ww_end <= 1'b1; acc[rpc_pkg::C_WINDOW_WATCHDOG] = 1'b1; end
        default: begin addr <= rpc_pkg::A_PWR_CTRL; wdata <= 32'h120; wr <= 1'b1; acc[rpc_pkg::C_LP] = 1'b1; end
      endcase
      @(posedge clk);
      pin_req <= 1'b0; wr <= 1'b0; iw_end <= 1'b0; ww_end <= 1'b0;
      wait_sr(1'b0);
      wait_sr(1'b1);
      rd_reg(rpc_pkg::A_RCSR, acc, 32'h3f);
      rd_reg(rpc_pkg::A_PWR_CTRL, 32'h0, 32'h1ff);
    end
    // supply below the power-on level keeps the system in reset
    por_below <= 1'b1;
    idle(30);
    chk(32'(srn), 32'h0);
    por_below <= 1'b0;
    wait_sr(1'b1);
    acc[rpc_pkg::C_POR] = 1'b1;
    rd_reg(rpc_pkg::A_RCSR, acc, 32'h3f);
    // detector on a random threshold, rising edge then falling edge armed on line 16
    t = $urandom_range(7, 0);
    wr_reg(rpc_pkg::A_LINE16, 32'h3);
    wr_reg(rpc_pkg::A_PWR_CTRL, 32'h10 | 32'(t));
    detector_below <= 8'h01 << t;
    idle(10);
    rd_reg(rpc_pkg::A_PWR_STAT, 32'h1, 32'h7);
    chk(32'(irq), 32'h1);
    wr_reg(rpc_pkg::A_LINE16, 32'hd);
    idle(3);
    chk(32'(irq), 32'h0);
    wr_reg(rpc_pkg::A_PWR_CTRL, 32'h10 | 32'((t + 1) % 8));
    idle(10);
    rd_reg(rpc_pkg::A_PWR_STAT, 32'h0, 32'h1);
    chk(32'(irq), 32'h1);
    wr_reg(rpc_pkg::A_LINE16, 32'h0);
    idle(3);
    chk(32'(irq), 32'h0);
    wr_reg(rpc_pkg::A_PWR_CTRL, 32'(t));
    idle(10);
    rd_reg(rpc_pkg::A_PWR_STAT, 32'h0, 32'h1);
    detector_below <= 8'h00;
    // stop keeps state, standby loses it
    wr_reg(rpc_pkg::A_LINE16, 32'h1);
    wr_reg(rpc_pkg::A_PWR_CTRL, 32'h20);
    idle(3);
    chk({30'h0, reg_on, reg_lp}, 32'h3);
    rd_reg(rpc_pkg::A_PWR_STAT, 32'h2, 32'h6);
    wakeup <= 1'b1;
    idle(6);
    wakeup <= 1'b0;
    chk({30'h0, reg_on, reg_lp}, 32'h2);
    rd_reg(rpc_pkg::A_LINE16, 32'h1, 32'h7);
    wr_reg(rpc_pkg::A_PWR_CTRL, 32'h40);
    idle(3);
    chk(32'(reg_on), 32'h0);
    wakeup <= 1'b1;
    wait_sr(1'b0);
    wakeup <= 1'b0;
    wait_sr(1'b1);
    chk(32'(reg_on), 32'h1);
    rd_reg(rpc_pkg::A_LINE16, 32'h0, 32'h7);
    // clock output: every select in alternate mode, fast external source in bypass
    for (k = 0; k < 4; k++) begin
      wr_reg(rpc_pkg::A_CLK, 32'h102b | (32'(k) << rpc_pkg::CK_MCO));
      idle(3);
      chk(32'(cko_oe_n), 32'h0);
    end
    wr_reg(rpc_pkg::A_CLK, 32'h102b | (32'(rpc_pkg::MCO_IFO) << rpc_pkg::CK_MCO));
    idle(3);
    cnt = int'(cko);
    idle(1);
    chk(32'(cko), 32'(cnt == 0));
    chk({30'h0, famp, samp}, 32'h0);
    cnt = 0; ccnt = 0; scnt = 0;
    repeat (1000) begin
      idle(1);
      if (wtick === 1'b1) cnt++;
      if (ctick === 1'b1) ccnt++;
      if (stick === 1'b1) scnt++;
    end
    chk(32'(cnt), 32'h2);
    chk(32'(ccnt), 32'h2);
    chk(32'(scnt), 32'h3e8);
    // internal slow off, calendar from the external slow source in bypass
    wr_reg(rpc_pkg::A_CLK, 32'h2073);
    idle(3);
    chk({30'h0, cko_oe_n, cko}, 32'h2);
    cnt = 0; ccnt = 0;
    repeat (2000) begin
      idle(1);
      if (wtick === 1'b1) cnt++;
      if (ctick === 1'b1) ccnt++;
    end
    chk(32'(cnt), 32'h0);
    chk(32'(ccnt == 3 || ccnt == 4), 32'h1);
    chk({30'h0, famp, samp}, 32'h0);
    rd_reg(rpc_pkg::A_CLK, 32'h1 << rpc_pkg::CK_SRDY, 32'h1 << rpc_pkg::CK_SRDY);
    // pll fed from the internal source at x17 would pass the ceiling
    wr_reg(rpc_pkg::A_CLK, 32'h5 | (32'hf << rpc_pkg::CK_MUL));
    idle(20);
    wr_reg(rpc_pkg::A_CLK, 32'h5 | (32'hf << rpc_pkg::CK_MUL) | (32'h2 << rpc_pkg::CK_SW));
    idle(5);
    rd_reg(rpc_pkg::A_CLK, 32'h0, 32'h3 << rpc_pkg::CK_SWS);
    // x15 stays under the ceiling, so the switch goes through
    wr_reg(rpc_pkg::A_CLK, 32'h5 | (32'hd << rpc_pkg::CK_MUL) | (32'h2 << rpc_pkg::CK_SW));
    idle(5);
    rd_reg(rpc_pkg::A_CLK, 32'h2 << rpc_pkg::CK_SWS, 32'h3 << rpc_pkg::CK_SWS);
    idle(3);
    close_out();
  end
endmodule : reset_power_clock_supervisor_tb_top
`default_nettype wire
